// *** design/tcm_cfg.svh ***
// constants for the timer channel clock and mode select block
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

// register map: mode registers at base plus channel, clock selects likewise
`define TCM_ADDR_W        4
`define TCM_MODE_BASE     1'b0
`define TCM_CKS_BASE      1'b1
`define TCM_NUM_CH        6
`define TCM_LAST_CH       3'h5

// mode register layout
`define TCM_MODE_FIXED    2'h3
`define TCM_MODE_RST      6'h00
`define TCM_BFB_BIT       5
`define TCM_BFA_BIT       4
`define TCM_CKS_RST       3'h0
`define TCM_RD_IDLE       8'h00

// prescaler: a tap of shift k gives the system clock divided by 2**k
`define TCM_PRE_W         12
`define TCM_SH_DIV1       4'h0
`define TCM_SH_DIV4       4'h2
`define TCM_SH_DIV16      4'h4
`define TCM_SH_DIV64      4'h6
`define TCM_SH_DIV256     4'h8
`define TCM_SH_DIV1024    4'ha
`define TCM_SH_DIV4096    4'hc

// defaults for the channel 5 internal taps that have no known ratio
`define TCM_CH5_SH2_DEF   4'h4
`define TCM_CH5_SH3_DEF   4'h6
`define TCM_CH5_SH6_DEF   4'h8

// count clock select codes
`define TCM_CKS_0         3'h0
`define TCM_CKS_1         3'h1
`define TCM_CKS_2         3'h2
`define TCM_CKS_3         3'h3
`define TCM_CKS_4         3'h4
`define TCM_CKS_5         3'h5
`define TCM_CKS_6         3'h6
`define TCM_CKS_7         3'h7

// external pin lanes
`define TCM_PIN_A         0
`define TCM_PIN_B         1
`define TCM_PIN_C         2
`define TCM_PIN_D         3

`endif

// *** design/tcm_pkg.sv ***
// types shared by the timer channel clock and mode select block
package tcm_pkg;

	// decoded operating mode of one channel
	typedef enum logic [2:0] {
		TCM_NORMAL = 3'h0,
		TCM_PWM1   = 3'h1,
		TCM_PWM2   = 3'h2,
		TCM_PHASE1 = 3'h3,
		TCM_PHASE2 = 3'h4,
		TCM_PHASE3 = 3'h5,
		TCM_PHASE4 = 3'h6,
		TCM_NONE   = 3'h7
	} tcm_mode_t;

	// per-channel control handed to the counter logic
	typedef struct packed {
		logic      buffer_pair_b_enable;
		logic      buffer_pair_a_enable;
		logic [3:0] mode_field;
		tcm_mode_t mode;
	} tcm_chan_ctl_t;

endpackage : tcm_pkg

// *** design/tcm_clock_mode.sv ***
// count clock selection for channels 1 to 5 and operating mode registers for six timer channels
//
// What this block does
// - codes 000-011 count system clock /1, /4, /16, /64; channel 5 alike for 000, 001
// - channel 1: 100 pin A, 101 pin B, 110 /256, 111 channel 2 overflow
// - channel 2: 100 pin A, 101 pin B, 110 pin C, 111 /1024
// - channel 3: 100 pin A, 101 /1024, 110 /256, 111 /4096
// - channel 4: 100 pin A, 101 pin C, 110 /1024, 111 channel 5 overflow
// - channel 5: 100 pin A, 101 pin C, 111 pin D, others internal taps
// - phase counting on channels 1, 2, 4, 5 ignores the clock select
// - each channel has a mode register; change it only while stopped
// - mode bits 7 and 6 read one and ignore writes
// - bit 5 on channels 0, 3 makes register D buffer register B
// - bit 4 on channels 0, 3 makes register C buffer register A
// - channels 1, 2, 4, 5 read bits 5 and 4 as zero, writes ignored
// - mode field decodes normal, reserved, two pwm, four phase counting modes
//
// Local design decisions: strobed register access and the placing of the registers.
`include "tcm_cfg.svh"

module tcm_clock_mode #(
	parameter logic [3:0] CH5_SH_CODE2 = `TCM_CH5_SH2_DEF, // log2 of ratio for code 010
	parameter logic [3:0] CH5_SH_CODE3 = `TCM_CH5_SH3_DEF, // log2 of ratio for code 011
	parameter logic [3:0] CH5_SH_CODE6 = `TCM_CH5_SH6_DEF  // log2 of ratio for code 110
) (
	input  wire logic                        clk_sys_i,         // system clock
	input  wire logic                        arst_n_i,          // async reset, low
	input  wire logic [`TCM_ADDR_W-1:0]      addr_i,            // register address
	input  wire logic [7:0]                  wr_data_i,         // write data
	input  wire logic                        wr_en_i,           // write strobe
	input  wire logic                        rd_en_i,           // read strobe
	output logic [7:0]                       rd_data_o,         // read data, next cycle
	input  wire logic                        ext_clk_pin_a_i,   // external clock a
	input  wire logic                        ext_clk_pin_b_i,   // external clock b
	input  wire logic                        ext_clk_pin_c_i,   // external clock c
	input  wire logic                        ext_clk_pin_d_i,   // external clock d
	input  wire logic                        counter_ch2_ovf_i, // ch2 over/underflow pulse
	input  wire logic                        counter_ch5_ovf_i, // ch5 over/underflow pulse
	output logic [5:1]                       count_en_o,        // count enables ch1..5
	output tcm_pkg::tcm_chan_ctl_t [5:0]     chan_ctl_o         // mode control per channel
);

	// only channels 0 and 3 own the C and D registers
	function automatic logic has_buf(input logic [2:0] ch);
		return (ch == 3'h0) || (ch == 3'h3);
	endfunction : has_buf

	// tap of the free prescaler: true once every 2**sh cycles
	function automatic logic div_tick(input logic [`TCM_PRE_W-1:0] cnt,
	                                  input logic [3:0] sh);
		logic [`TCM_PRE_W:0] mask;
		mask = (13'h1 << sh) - 13'h1;
		return (cnt & mask[`TCM_PRE_W-1:0]) == mask[`TCM_PRE_W-1:0];
	endfunction : div_tick

	// decode the 4-bit mode field; phase modes are not offered on buffered channels
	function automatic tcm_pkg::tcm_mode_t decode_mode(input logic [3:0] f,
	                                                   input logic [2:0] ch);
		tcm_pkg::tcm_mode_t m;
		m = tcm_pkg::TCM_NONE;
		case (f)
			4'h0: m = tcm_pkg::TCM_NORMAL;
			4'h2: m = tcm_pkg::TCM_PWM1;
			4'h3: m = tcm_pkg::TCM_PWM2;
			4'h4: m = has_buf(ch) ? tcm_pkg::TCM_NONE : tcm_pkg::TCM_PHASE1;
			4'h5: m = has_buf(ch) ? tcm_pkg::TCM_NONE : tcm_pkg::TCM_PHASE2;
			4'h6: m = has_buf(ch) ? tcm_pkg::TCM_NONE : tcm_pkg::TCM_PHASE3;
			4'h7: m = has_buf(ch) ? tcm_pkg::TCM_NONE : tcm_pkg::TCM_PHASE4;
			default: m = tcm_pkg::TCM_NONE;
		endcase
		return m;
	endfunction : decode_mode

	function automatic logic is_phase(input tcm_pkg::tcm_mode_t m);
		return (m == tcm_pkg::TCM_PHASE1) || (m == tcm_pkg::TCM_PHASE2) ||
		       (m == tcm_pkg::TCM_PHASE3) || (m == tcm_pkg::TCM_PHASE4);
	endfunction : is_phase

	logic [5:0]            mode_q [`TCM_NUM_CH];
	logic [5:0]            mode_d [`TCM_NUM_CH];
	logic [2:0]            cks_q  [5:1];
	logic [2:0]            cks_d  [5:1];
	logic [`TCM_PRE_W-1:0] pre_q;
	logic [`TCM_PRE_W-1:0] pre_d;
	logic [3:0]            pin_s1_q;
	logic [3:0]            pin_s2_q;
	logic [3:0]            pin_s3_q;
	logic [3:0]            pin_edge;
	logic [5:1]            cen_d;
	logic [7:0]            rd_d;
	tcm_pkg::tcm_chan_ctl_t [5:0] ctl_d;

	// register writes; accepted at any time, keeping them static is software's job
	always_comb begin
		for (int n = 0; n < `TCM_NUM_CH; n++) begin
			mode_d[n] = mode_q[n];
			if (wr_en_i && addr_i[3] == `TCM_MODE_BASE && addr_i[2:0] == 3'(n)) begin
				mode_d[n] = wr_data_i[5:0];
				if (!has_buf(3'(n))) begin
					mode_d[n][`TCM_BFB_BIT] = 1'b0;
					mode_d[n][`TCM_BFA_BIT] = 1'b0;
				end
			end
		end
		for (int n = 1; n < `TCM_NUM_CH; n++) begin
			cks_d[n] = cks_q[n];
			if (wr_en_i && addr_i[3] == `TCM_CKS_BASE && addr_i[2:0] == 3'(n)) begin
				cks_d[n] = wr_data_i[2:0];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int n = 0; n < `TCM_NUM_CH; n++) begin
				mode_q[n] <= `TCM_MODE_RST;
			end
			for (int n = 1; n < `TCM_NUM_CH; n++) begin
				cks_q[n] <= `TCM_CKS_RST;
			end
		end else begin
			mode_q <= mode_d;
			cks_q  <= cks_d;
		end
	end

	// read mux; mode bits 7:6 are not stored, they are tied high on the way out
	always_comb begin
		rd_d = `TCM_RD_IDLE;
		if (rd_en_i) begin
			if (addr_i[3] == `TCM_MODE_BASE && addr_i[2:0] <= `TCM_LAST_CH) begin
				rd_d = {`TCM_MODE_FIXED, mode_q[addr_i[2:0]]};
			end else if (addr_i[3] == `TCM_CKS_BASE && addr_i[2:0] != 3'h0 &&
			             addr_i[2:0] <= `TCM_LAST_CH) begin
				rd_d = {5'h00, cks_q[addr_i[2:0]]};
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= `TCM_RD_IDLE;
		end else begin
			rd_data_o <= rd_d;
		end
	end

	// free-running prescaler; one counter feeds every divided tap
	always_comb begin
		pre_d = pre_q + 12'h001;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_d;
		end
	end

	// pin synchroniser plus edge stage; the detector compares the second stage with the third
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
		end else begin
			pin_s1_q <= {ext_clk_pin_d_i, ext_clk_pin_c_i, ext_clk_pin_b_i, ext_clk_pin_a_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// rising edges only; edge polarity selection lives outside this block
	assign pin_edge = pin_s2_q & ~pin_s3_q;

	// count enable selection per channel
	always_comb begin
		cen_d = 5'h00;
		case (cks_q[1])
			`TCM_CKS_0: cen_d[1] = div_tick(pre_q, `TCM_SH_DIV1);
			`TCM_CKS_1: cen_d[1] = div_tick(pre_q, `TCM_SH_DIV4);
			`TCM_CKS_2: cen_d[1] = div_tick(pre_q, `TCM_SH_DIV16);
			`TCM_CKS_3: cen_d[1] = div_tick(pre_q, `TCM_SH_DIV64);
			`TCM_CKS_4: cen_d[1] = pin_edge[`TCM_PIN_A];
			`TCM_CKS_5: cen_d[1] = pin_edge[`TCM_PIN_B];
			`TCM_CKS_6: cen_d[1] = div_tick(pre_q, `TCM_SH_DIV256);
			`TCM_CKS_7: cen_d[1] = counter_ch2_ovf_i;
			default:    cen_d[1] = 1'b0;
		endcase
		case (cks_q[2])
			`TCM_CKS_0: cen_d[2] = div_tick(pre_q, `TCM_SH_DIV1);
			`TCM_CKS_1: cen_d[2] = div_tick(pre_q, `TCM_SH_DIV4);
			`TCM_CKS_2: cen_d[2] = div_tick(pre_q, `TCM_SH_DIV16);
			`TCM_CKS_3: cen_d[2] = div_tick(pre_q, `TCM_SH_DIV64);
			`TCM_CKS_4: cen_d[2] = pin_edge[`TCM_PIN_A];
			`TCM_CKS_5: cen_d[2] = pin_edge[`TCM_PIN_B];
			`TCM_CKS_6: cen_d[2] = pin_edge[`TCM_PIN_C];
			`TCM_CKS_7: cen_d[2] = div_tick(pre_q, `TCM_SH_DIV1024);
			default:    cen_d[2] = 1'b0;
		endcase
		case (cks_q[3])
			`TCM_CKS_0: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV1);
			`TCM_CKS_1: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV4);
			`TCM_CKS_2: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV16);
			`TCM_CKS_3: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV64);
			`TCM_CKS_4: cen_d[3] = pin_edge[`TCM_PIN_A];
			`TCM_CKS_5: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV1024);
			`TCM_CKS_6: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV256);
			`TCM_CKS_7: cen_d[3] = div_tick(pre_q, `TCM_SH_DIV4096);
			default:    cen_d[3] = 1'b0;
		endcase
		case (cks_q[4])
			`TCM_CKS_0: cen_d[4] = div_tick(pre_q, `TCM_SH_DIV1);
			`TCM_CKS_1: cen_d[4] = div_tick(pre_q, `TCM_SH_DIV4);
			`TCM_CKS_2: cen_d[4] = div_tick(pre_q, `TCM_SH_DIV16);
			`TCM_CKS_3: cen_d[4] = div_tick(pre_q, `TCM_SH_DIV64);
			`TCM_CKS_4: cen_d[4] = pin_edge[`TCM_PIN_A];
			`TCM_CKS_5: cen_d[4] = pin_edge[`TCM_PIN_C];
			`TCM_CKS_6: cen_d[4] = div_tick(pre_q, `TCM_SH_DIV1024);
			`TCM_CKS_7: cen_d[4] = counter_ch5_ovf_i;
			default:    cen_d[4] = 1'b0;
		endcase
		case (cks_q[5])
			`TCM_CKS_0: cen_d[5] = div_tick(pre_q, `TCM_SH_DIV1);
			`TCM_CKS_1: cen_d[5] = div_tick(pre_q, `TCM_SH_DIV4);
			`TCM_CKS_2: cen_d[5] = div_tick(pre_q, CH5_SH_CODE2);
			`TCM_CKS_3: cen_d[5] = div_tick(pre_q, CH5_SH_CODE3);
			`TCM_CKS_4: cen_d[5] = pin_edge[`TCM_PIN_A];
			`TCM_CKS_5: cen_d[5] = pin_edge[`TCM_PIN_C];
			`TCM_CKS_6: cen_d[5] = div_tick(pre_q, CH5_SH_CODE6);
			`TCM_CKS_7: cen_d[5] = pin_edge[`TCM_PIN_D];
			default:    cen_d[5] = 1'b0;
		endcase
		// phase counting drives the counter from its own pins, so the select is void
		for (int n = 1; n < `TCM_NUM_CH; n++) begin
			if (is_phase(decode_mode(mode_q[n][3:0], 3'(n)))) begin
				cen_d[n] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_en_o <= 5'h00;
		end else begin
			count_en_o <= cen_d;
		end
	end

	// mode control outputs, registered so the counters see stable values
	always_comb begin
		for (int n = 0; n < `TCM_NUM_CH; n++) begin
			ctl_d[n].buffer_pair_b_enable = mode_q[n][`TCM_BFB_BIT];
			ctl_d[n].buffer_pair_a_enable = mode_q[n][`TCM_BFA_BIT];
			ctl_d[n].mode_field           = mode_q[n][3:0];
			ctl_d[n].mode                 = decode_mode(mode_q[n][3:0], 3'(n));
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chan_ctl_o <= '0;
		end else begin
			chan_ctl_o <= ctl_d;
		end
	end

endmodule : tcm_clock_mode

// *** dv/tcm_clock_mode_asserts.sv ***
// assertion checker for the timer clock and mode select block
module tcm_clock_mode_asserts (
	input wire logic                         clk_sys_i,         // clock
	input wire logic                         arst_n_i,          // reset, low
	input wire logic [3:0]                   addr_i,            // address
	input wire logic [7:0]                   wr_data_i,         // write data
	input wire logic                         wr_en_i,           // write strobe
	input wire logic                         rd_en_i,           // read strobe
	input wire logic [7:0]                   rd_data_o,         // read data
	input wire logic                         ext_clk_pin_a_i,   // pin a
	input wire logic                         ext_clk_pin_b_i,   // pin b
	input wire logic                         ext_clk_pin_c_i,   // pin c
	input wire logic                         ext_clk_pin_d_i,   // pin d
	input wire logic                         counter_ch2_ovf_i, // ch2 overflow
	input wire logic                         counter_ch5_ovf_i, // ch5 overflow
	input wire logic [5:1]                   count_en_o,        // count enables
	input wire tcm_pkg::tcm_chan_ctl_t [5:0] chan_ctl_o         // channel control
);
	logic [2:0] cks1_q, cks1_d;
	logic       norm1;
	// shadow of the channel 1 clock select, since that register is not a port
	always_comb begin
		cks1_d = cks1_q;
		if (wr_en_i && addr_i == 4'h9)
			cks1_d = wr_data_i[2:0];
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cks1_q <= 3'h0;
		else
			cks1_q <= cks1_d;
	end
	// reserved mode codes have no defined counting, so only these are judged
	assign norm1 = chan_ctl_o[1].mode <= tcm_pkg::TCM_PWM2;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	rd_idle_a: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
		else $error("read data not idle");
	mode_fixed_a: assert property ($past(rd_en_i) && $past(addr_i) < 4'h6 |-> rd_data_o[7:6] == 2'h3)
		else $error("mode bits 7:6 not one");
	narrow_buf_a: assert property ($past(rd_en_i) && $past(addr_i) inside {4'h1, 4'h2, 4'h4, 4'h5}
		|-> rd_data_o[5:4] == 2'h0) else $error("buffer bits read nonzero");
	unmapped_a: assert property ($past(rd_en_i) && $past(addr_i) inside {[4'h6:4'h8], 4'he, 4'hf}
		|-> rd_data_o == 8'h00) else $error("unmapped read nonzero");
	ctl_buf_a: assert property ({chan_ctl_o[1][8:7], chan_ctl_o[2][8:7], chan_ctl_o[4][8:7],
		chan_ctl_o[5][8:7]} == 8'h00) else $error("buffer enable on narrow channel");
	ctl_write_a: assert property (wr_en_i && addr_i == 4'h3 |-> ##2
		chan_ctl_o[3][8:3] == $past(wr_data_i[5:0], 2)) else $error("ch3 control not updated");
	phase_ch1_a: assert property (chan_ctl_o[1].mode_field[3:2] == 2'h1 |-> !count_en_o[1])
		else $error("ch1 counts in phase mode");
	phase_ch4_a: assert property (chan_ctl_o[4].mode_field[3:2] == 2'h1 |-> !count_en_o[4])
		else $error("ch4 counts in phase mode");
	div1_a: assert property ($past(arst_n_i) && $past(cks1_q) == 3'h0 && norm1 |-> count_en_o[1])
		else $error("ch1 full rate enable missing");
	ovf_a: assert property ($past(cks1_q) == 3'h7 && norm1 |->
		count_en_o[1] == $past(counter_ch2_ovf_i)) else $error("ch1 overflow enable wrong");
	pin_a: assert property (cks1_q == 3'h4 && norm1 && $rose(ext_clk_pin_a_i) |->
		##[2:3] count_en_o[1]) else $error("ch1 pin enable missing");

	ctl_write_c: cover property (wr_en_i && addr_i == 4'h3);
	ovf_c: cover property ($past(cks1_q) == 3'h7 && count_en_o[1]);
	pin_c: cover property (cks1_q == 3'h4 && $rose(ext_clk_pin_a_i));
endmodule : tcm_clock_mode_asserts

bind tcm_clock_mode tcm_clock_mode_asserts i_tcm_clock_mode_asserts (.*);

// *** dv/tcm_clock_mode_tb_top.sv ***
// self-checking bench for the timer clock and mode select block
module tcm_clock_mode_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wr_data_i = 8'h00;
	logic [5:0] src = 6'h00; // ch5 ovf, ch2 ovf, pins d c b a
	wire ext_clk_pin_a_i = src[0];
	wire ext_clk_pin_b_i = src[1];
	wire ext_clk_pin_c_i = src[2];
	wire ext_clk_pin_d_i = src[3];
	wire counter_ch2_ovf_i = src[4];
	wire counter_ch5_ovf_i = src[5];
	wire [7:0] rd_data_o;
	wire [5:1] count_en_o;
	tcm_pkg::tcm_chan_ctl_t [5:0] chan_ctl_o;
	int n_errors = 0, check_count = 0;
	// unusual channel 5 taps so the ratios are not mistaken for defaults
	tcm_clock_mode #(.CH5_SH_CODE2(4'h3), .CH5_SH_CODE3(4'h5), .CH5_SH_CODE6(4'h7))
		i_tcm_clock_mode (.*);
	always #50 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// bus cycles: one strobe cycle, data sampled in the cycle after a read
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) {wr_en_i, addr_i, wr_data_i} <= {1'b1, a, d};
		@(posedge clk_sys_i) wr_en_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_i) {rd_en_i, addr_i} <= {1'b1, a};
		@(posedge clk_sys_i) rd_en_i <= 1'b0;
		@(negedge clk_sys_i) d = rd_data_o;
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : settle

	task automatic t_regs();
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), v);
			chk(v, i < 6 ? 8'hc0 : 8'h00);
			// reserved bit 3 stays zero, and bit 2 too where phase counting is absent
			wr(4'(i), i == 0 || i == 3 ? 8'hf3 : 8'hf7);
			rd(4'(i), v);
			chk(v, i == 0 || i == 3 ? 8'hf3 : i < 6 ? 8'hc7 : i inside {[9:13]} ? 8'h07 : 8'h00);
			wr(4'(i), 8'h00);
		end
		$display("register test done");
	endtask : t_regs

	task automatic t_mode();
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			for (int j = 1; j < 6; j++)
				wr(4'(j), 8'(j == 3 && i > 3 ? 0 : i));
			settle();
			m = i == 1 ? 3'h7 : i == 0 ? 3'h0 : 3'(i - 1);
			for (int j = 1; j < 6; j++) begin
				chk(chan_ctl_o[j].mode, j == 3 && i > 3 ? 3'h0 : m);
				if (j != 3 && i != 1)
					chk(count_en_o[j], i < 4);
			end
		end
		wr(4'h0, 8'h33);
		settle();
		chk(chan_ctl_o[0], {2'h3, 4'h3, 3'h2});
		for (int j = 0; j < 6; j++)
			wr(4'(j), 8'h00);
		$display("mode test done");
	endtask : t_mode

	// distance between successive enables equals the selected ratio
	task automatic t_div();
		int tab [15][3] = '{'{1, 0, 1}, '{1, 1, 4}, '{1, 2, 16}, '{1, 3, 64}, '{1, 6, 256},
			'{2, 7, 1024}, '{3, 5, 1024}, '{3, 6, 256}, '{3, 7, 4096}, '{4, 6, 1024},
			'{5, 0, 1}, '{5, 1, 4}, '{5, 2, 8}, '{5, 3, 32}, '{5, 6, 128}};
		int n;
		for (int k = 0; k < 15; k++) begin
			wr(4'(8 + tab[k][0]), 8'(tab[k][1]));
			settle();
			for (int p = 0; p < 2; p++) begin
				n = 0;
				do begin
					@(negedge clk_sys_i);
					n++;
				end while (count_en_o[tab[k][0]] !== 1'b1 && n < 5000);
			end
			chk(n, tab[k][2]);
		end
		$display("divider test done");
	endtask : t_div

	// selected source gives one enable, another source gives none
	task automatic t_ext();
		int tab [13][3] = '{'{1, 4, 0}, '{1, 5, 1}, '{1, 7, 4}, '{2, 4, 0}, '{2, 5, 1},
			'{2, 6, 2}, '{3, 4, 0}, '{4, 4, 0}, '{4, 5, 2}, '{4, 7, 5}, '{5, 4, 0},
			'{5, 5, 2}, '{5, 7, 3}};
		int hits;
		for (int k = 0; k < 13; k++) begin
			wr(4'(8 + tab[k][0]), 8'(tab[k][1]));
			for (int w = 0; w < 2; w++) begin
				hits = 0;
				@(posedge clk_sys_i) src[(tab[k][2] + w) % 6] <= 1'b1;
				@(posedge clk_sys_i) src <= 6'h00;
				repeat (8) begin
					@(negedge clk_sys_i);
					hits += int'(count_en_o[tab[k][0]] === 1'b1);
				end
				chk(hits, w == 0);
			end
		end
		$display("source test done");
	endtask : t_ext

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	// main sequence, ending with a reset in mid-run
	initial begin
		logic [7:0] v;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_mode();
		t_div();
		t_ext();
		wr(4'h3, 8'h33);
		@(posedge clk_sys_i) arst_n_i <= 1'b0;
		@(negedge clk_sys_i) chk(chan_ctl_o[3], 9'h000);
		@(posedge clk_sys_i) arst_n_i <= 1'b1;
		rd(4'h3, v);
		chk(v, 8'hc0);
		stop_test();
	end
	// run needs about 15000 cycles; the 40000-cycle limit means a hang
	initial begin
		#4000000;
		n_errors++;
		$display("watchdog expired");
		stop_test();
	end
endmodule : tcm_clock_mode_tb_top
